// ---- rtl/winding_power_manager.sv ----
// Winding power manager: idle timers, current ramp and critical-parameter alarm.
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module winding_power_manager
	import wpm_pkg::*;
#(
	parameter int TICK_DIV    = TICK_CYCLES,
	parameter int LINK_LOSS   = LINK_LOSS_MS
) (
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        resetn,
	// Register port.
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdata,
	// Motion control.
	input  wire logic        motionStopped,
	input  wire logic        moveStart,
	input  wire logic        stopCmd,
	input  wire logic        fwResetReq,
	input  wire logic        linkActivity,
	output logic             motionHalt,
	output logic             alarm,
	output logic             linkLost,
	// Winding driver and monitors.
	input  wire monitor_s    mon,
	output logic             driverEnable,
	output logic      [15:0] windingCurrent
);

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	logic [15:0] ctrl_ff, hold_ff, holdDly_ff, offDly_ff, ramp_ff;
	logic [15:0] nominal_ff, vmin_ff, vmax_ff, imax_ff, tmax_ff;
	logic [15:0] rdata_ff;
	fault_s      flags_ff;

	// Register writes; hold value is a percentage, delays in ms and s.
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ctrl_ff    <= RST_CTRL;
			hold_ff    <= RST_HOLD;
			holdDly_ff <= RST_HOLDDLY;
			offDly_ff  <= RST_OFFDLY;
			ramp_ff    <= RST_RAMP;
			nominal_ff <= RST_NOMINAL;
			vmin_ff    <= RST_VMIN;
			vmax_ff    <= RST_VMAX;
			imax_ff    <= RST_IMAX;
			tmax_ff    <= RST_TMAX;
		end else if (regWr) begin
			case (regAddr)
				REG_CTRL:    ctrl_ff    <= regWdata;
				REG_HOLD:    hold_ff    <= regWdata;
				REG_HOLDDLY: holdDly_ff <= regWdata;
				REG_OFFDLY:  offDly_ff  <= regWdata;
				REG_RAMP:    ramp_ff    <= regWdata;
				REG_NOMINAL: nominal_ff <= regWdata;
				REG_VMIN:    vmin_ff    <= regWdata;
				REG_VMAX:    vmax_ff    <= regWdata;
				REG_IMAX:    imax_ff    <= regWdata;
				REG_TMAX:    tmax_ff    <= regWdata;
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Millisecond tick
	// ****************************************************************
	logic [31:0] div_ff;
	wire         msTick = (div_ff == 32'(TICK_DIV - 1));

	// Free running divider; every timer here counts these ticks.
	// Timers therefore have a resolution of one tick: a delay of N ms may end up
	// to one tick early, depending on the divider phase when the count starts.
	always_ff @(posedge mclk) begin
		if (!resetn || msTick)
			div_ff <= 32'h0;
		else
			div_ff <= div_ff + 32'h1;
	end

	// ****************************************************************
	// Idle timer
	// ****************************************************************
	logic [31:0] idleMs_ff;
	logic        stopped_ff;

	// Elapsed time since stop entry; clearing on entry marks the reference.
	// Counting elapsed time instead of storing a timestamp lets delay edits act live.
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			idleMs_ff  <= 32'h0;
			stopped_ff <= 1'b0;
		end else begin
			stopped_ff <= motionStopped && !moveStart;
			if (moveStart || !motionStopped)
				idleMs_ff <= 32'h0;
			else if (!stopped_ff)
				idleMs_ff <= 32'h0;
			else if (msTick && idleMs_ff != 32'hffffffff)
				idleMs_ff <= idleMs_ff + 32'h1;
		end
	end

	// Idle decisions, recomputed every cycle from the live settings.
	// A longer power-off delay written after power-off makes idleOff false again,
	// which re-powers the windings until the new delay has elapsed.
	wire [31:0] offMs     = 32'(offDly_ff) * MS_PER_S;
	wire        idleHold  = stopped_ff && ctrl_ff[CTRL_HOLD_EN] && idleMs_ff >= 32'(holdDly_ff);
	wire        idleOff   = stopped_ff && ctrl_ff[CTRL_OFF_EN] && idleMs_ff >= offMs;

	// ****************************************************************
	// Critical parameters
	// ****************************************************************
	logic [15:0] linkMs_ff;
	fault_s      faultNow;

	assign faultNow.underVolt   = ctrl_ff[CTRL_LOWV_EN] && mon.supplyMv10 < vmin_ff;
	assign faultNow.overCurrent = mon.supplyMa > imax_ff;
	assign faultNow.overVolt    = mon.supplyMv10 > vmax_ff;
	assign faultNow.overTemp    = mon.tempDc > tmax_ff;
	assign faultNow.drvHot      = ctrl_ff[CTRL_DRVHOT_EN] && mon.drvHot;
	assign faultNow.drvFault    = ctrl_ff[CTRL_BRIDGE_EN] && mon.drvFault;
	assign faultNow.wrongLimit  = ctrl_ff[CTRL_SWAP_EN] && mon.wrongLimit;
	assign faultNow.linkLoss    = linkLost;

	wire anyFault = |faultNow[6:0];

	// Link watchdog; link loss is reported but does not raise alarm.
	// The counter saturates at the limit, so a long silence cannot wrap around
	// and make the loss indication drop by itself.
	always_ff @(posedge mclk) begin
		if (!resetn || !ctrl_ff[CTRL_LINK_EN] || linkActivity)
			linkMs_ff <= 16'h0;
		else if (msTick && linkMs_ff != 16'(LINK_LOSS))
			linkMs_ff <= linkMs_ff + 16'h1;
	end
	assign linkLost = ctrl_ff[CTRL_LINK_EN] && linkMs_ff == 16'(LINK_LOSS);

	// Status flags: sticky mode holds them until a status read; a new fault wins.
	logic stickyClr;
	assign stickyClr = regRd && regAddr == REG_STATUS;
	always_ff @(posedge mclk) begin
		if (!resetn)
			flags_ff <= '0;
		else if (!ctrl_ff[CTRL_STICKY_EN])
			flags_ff <= faultNow;
		else
			flags_ff <= faultNow | (stickyClr ? fault_s'('0) : flags_ff);
	end

	// Alarm latch; STOP clears it only once every cause has gone.
	// A STOP that arrives while a cause is still present is ignored, so the
	// controlling side has to send it again once the readings are back in range.
	logic alarm_ff;
	always_ff @(posedge mclk) begin
		if (!resetn)
			alarm_ff <= 1'b0;
		else if (anyFault)
			alarm_ff <= 1'b1;
		else if (stopCmd)
			alarm_ff <= 1'b0;
	end
	assign alarm      = alarm_ff;
	assign motionHalt = alarm_ff || anyFault;

	// ****************************************************************
	// Current target and ramp
	// ****************************************************************
	logic [15:0] cur_ff;
	logic [15:0] accum_ff;
	logic [15:0] stepLvl_ff;
	logic [15:0] prevHold_ff;
	logic [15:0] rateRef_ff;
	logic        rateHold_ff;
	power_e      pw_ff;

	// The ramp is a rate limiter, not a timed sequence: every millisecond the
	// current moves one step toward whatever the target is at that moment.
	// A target that changes mid-ramp is therefore followed from the present
	// level with no step, and no separate ramp timer has to be restarted.
	// The price is that a swing always takes whole milliseconds, rounded up.

	// Hold level as share of nominal.
	function automatic logic [15:0] pctOf(input logic [15:0] nom, input logic [15:0] pct);
		logic [31:0] p;
		p = 32'(nom) * 32'(pct) / 32'd100;
		return p[15:0];
	endfunction

	wire        kill      = alarm_ff || anyFault || fwResetReq;
	wire        wantOff   = kill || idleOff;
	wire [15:0] holdLvl   = pctOf(nominal_ff, hold_ff);
	wire [15:0] runTarget = idleHold ? holdLvl : nominal_ff;
	wire [15:0] target    = (pw_ff == PW_ON || pw_ff == PW_RAMPUP) ? runTarget : 16'h0;
	wire        rampOn    = ctrl_ff[CTRL_RAMP_EN] && ramp_ff != 16'h0;

	// Hold setting change: keep the higher of old and new for the rate reference.
	// The previous setting is overwritten one cycle after the change, so the
	// higher of the two is captured at that moment and held in its own register.
	// Without it the rate would follow only the new setting after one cycle.
	wire        holdChg   = hold_ff != prevHold_ff;
	wire [15:0] maxHold   = (hold_ff > prevHold_ff) ? hold_ff : prevHold_ff;
	wire [15:0] refLvl    = rateHold_ff ? pctOf(nominal_ff, rateRef_ff) : nominal_ff;

	// Per-ms step: reference level over ramp time, so partial swings scale linearly.
	// A step of at least one keeps a very long ramp time from stalling the current.
	// The step is registered so the divider does not sit in the ramp update path.
	wire [15:0] stepRaw   = (ramp_ff == 16'h0) ? refLvl : refLvl / ramp_ff;
	wire [15:0] step      = (stepRaw == 16'h0) ? 16'h1 : stepRaw;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			prevHold_ff <= RST_HOLD;
			rateRef_ff  <= RST_HOLD;
			rateHold_ff <= 1'b0;
			stepLvl_ff  <= 16'h0;
		end else begin
			stepLvl_ff <= step;
			if (holdChg) begin
				rateHold_ff <= 1'b1;
				rateRef_ff  <= maxHold;
				prevHold_ff <= hold_ff;
			end else if (cur_ff == target) begin
				rateHold_ff <= 1'b0;
			end
		end
	end

	// Power sequence: output enabled at zero then ramp up; ramp down then disable.
	// The output stage is only released once the current has reached zero, so
	// the windings never see an abrupt cut while soft ramping is on. A kill
	// request skips the wait: the current is already forced to zero that cycle.
	// A power-off that is withdrawn mid-ramp turns back toward the run target.
	always_ff @(posedge mclk) begin
		if (!resetn)
			pw_ff <= PW_OFF;
		else begin
			case (pw_ff)
				PW_OFF:    if (!wantOff) pw_ff <= PW_RAMPUP;
				PW_RAMPUP: if (wantOff) pw_ff <= PW_RAMPDN;
				           else if (cur_ff == runTarget) pw_ff <= PW_ON;
				PW_ON:     if (wantOff) pw_ff <= PW_RAMPDN;
				PW_RAMPDN: if (cur_ff == 16'h0 || kill) pw_ff <= PW_OFF;
				           else if (!wantOff) pw_ff <= PW_RAMPUP;
				default:   pw_ff <= PW_OFF;
			endcase
		end
	end

	// Current walks toward the target from where it stands, one step per ms.
	// Kill has priority over everything so alarm and firmware reset bypass the
	// ramp. With ramping off, the current follows the target in the next cycle.
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cur_ff   <= 16'h0;
			accum_ff <= 16'h0;
		end else if (kill) begin
			cur_ff   <= 16'h0;
			accum_ff <= 16'h0;
		end else if (!rampOn) begin
			cur_ff   <= (pw_ff == PW_OFF) ? 16'h0 : target;
			accum_ff <= 16'h0;
		end else if (msTick && cur_ff != target) begin
			accum_ff <= 16'h0;
			if (cur_ff < target)
				cur_ff <= (target - cur_ff > stepLvl_ff) ? cur_ff + stepLvl_ff : target;
			else
				cur_ff <= (cur_ff - target > stepLvl_ff) ? cur_ff - stepLvl_ff : target;
		end
	end

	assign windingCurrent = cur_ff;
	assign driverEnable   = pw_ff != PW_OFF;

	// ****************************************************************
	// Register read port
	// ****************************************************************
	logic [15:0] rdSel;
	always_comb begin
		case (regAddr)
			REG_CTRL:    rdSel = ctrl_ff;
			REG_HOLD:    rdSel = hold_ff;
			REG_HOLDDLY: rdSel = holdDly_ff;
			REG_OFFDLY:  rdSel = offDly_ff;
			REG_RAMP:    rdSel = ramp_ff;
			REG_NOMINAL: rdSel = nominal_ff;
			REG_VMIN:    rdSel = vmin_ff;
			REG_VMAX:    rdSel = vmax_ff;
			REG_IMAX:    rdSel = imax_ff;
			REG_TMAX:    rdSel = tmax_ff;
			REG_STATUS:  rdSel = {5'h0, alarm_ff, pw_ff, flags_ff};
			REG_CURRENT: rdSel = cur_ff;
			default:     rdSel = 16'h0;
		endcase
	end

	// Read data stands only in the cycle after the strobe.
	// Returning zero outside the read slot lets several readers share one bus
	// with a plain OR, at the cost of one flip-flop stage of read latency.
	always_ff @(posedge mclk) begin
		if (!resetn || !regRd)
			rdata_ff <= 16'h0;
		else
			rdata_ff <= rdSel;
	end
	assign regRdata = rdata_ff;

endmodule

`default_nettype wire

// ---- rtl/wpm_pkg.sv ----
// Package with constants, register map and types of the winding power manager.
package wpm_pkg;

	// ****************************************************************
	// Register map (word index on the plain register port)
	// ****************************************************************
	localparam logic [3:0] REG_CTRL     = 4'h0;
	localparam logic [3:0] REG_HOLD     = 4'h1;
	localparam logic [3:0] REG_HOLDDLY  = 4'h2;
	localparam logic [3:0] REG_OFFDLY   = 4'h3;
	localparam logic [3:0] REG_RAMP     = 4'h4;
	localparam logic [3:0] REG_NOMINAL  = 4'h5;
	localparam logic [3:0] REG_VMIN     = 4'h6;
	localparam logic [3:0] REG_VMAX     = 4'h7;
	localparam logic [3:0] REG_IMAX     = 4'h8;
	localparam logic [3:0] REG_TMAX     = 4'h9;
	localparam logic [3:0] REG_STATUS   = 4'ha;
	localparam logic [3:0] REG_CURRENT  = 4'hb;

	// ****************************************************************
	// Control register field positions
	// ****************************************************************
	localparam int CTRL_HOLD_EN   = 0;
	localparam int CTRL_OFF_EN    = 1;
	localparam int CTRL_RAMP_EN   = 2;
	localparam int CTRL_LOWV_EN   = 3;
	localparam int CTRL_DRVHOT_EN = 4;
	localparam int CTRL_BRIDGE_EN = 5;
	localparam int CTRL_SWAP_EN   = 6;
	localparam int CTRL_STICKY_EN = 7;
	localparam int CTRL_LINK_EN   = 8;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [15:0] RST_CTRL    = 16'h0023;
	localparam logic [15:0] RST_HOLD    = 16'h0032;
	localparam logic [15:0] RST_HOLDDLY = 16'h0064;
	localparam logic [15:0] RST_OFFDLY  = 16'h0e10;
	localparam logic [15:0] RST_RAMP    = 16'h0064;
	localparam logic [15:0] RST_NOMINAL = 16'h03e8;
	localparam logic [15:0] RST_VMIN    = 16'h0258;
	localparam logic [15:0] RST_VMAX    = 16'h1770;
	localparam logic [15:0] RST_IMAX    = 16'h0fa0;
	localparam logic [15:0] RST_TMAX    = 16'h02bc;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_HZ        = 50000000;
	localparam int TICK_MS       = 1;
	localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
	localparam int MS_PER_S      = 1000;
	localparam int LINK_LOSS_MS  = 500;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		PW_OFF    = 2'b00,
		PW_RAMPUP = 2'b01,
		PW_ON     = 2'b11,
		PW_RAMPDN = 2'b10
	} power_e;

	typedef struct packed {
		logic [15:0] supplyMv10;
		logic [15:0] supplyMa;
		logic [15:0] tempDc;
		logic        drvHot;
		logic        drvFault;
		logic        wrongLimit;
	} monitor_s;

	typedef struct packed {
		logic linkLoss;
		logic wrongLimit;
		logic drvFault;
		logic drvHot;
		logic overTemp;
		logic overCurrent;
		logic overVolt;
		logic underVolt;
	} fault_s;

endpackage

// ---- test/winding_power_manager_tb_top.sv ----
// Self-checking testbench of the winding power manager.
`timescale 1ns/10ps
`default_nettype none
module winding_power_manager_tb_top;
	import wpm_pkg::*;
	typedef struct packed { logic [15:0] val; logic [15:0] msk; } note_s;
	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic [3:0]  regAddr = 4'h0;
	logic [15:0] regWdata = 16'h0000;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic        motionStopped = 1'b0;
	logic        moveStart = 1'b0;
	logic        stopCmd = 1'b0;
	logic        fwResetReq = 1'b0;
	logic        linkActivity = 1'b0;
	logic        linkOn = 1'b1;
	logic        rdPend = 1'b0;
	logic [2:0]  faultSel = 3'h0;
	logic [15:0] regRdata, windingCurrent;
	logic        motionHalt, alarm, linkLost, driverEnable;
	monitor_s    mon;
	note_s       notes[$];
	int          num_errors = 0;
	int          checks = 0;
	int          n;
	logic [15:0] rstv [10] = '{RST_CTRL, RST_HOLD, RST_HOLDDLY, RST_OFFDLY, RST_RAMP, RST_NOMINAL, RST_VMIN,
		RST_VMAX, RST_IMAX, RST_TMAX};

	// Ms tick and link timeout shortened so the run stays short.
	winding_power_manager #(.TICK_DIV(10), .LINK_LOSS(4)) uut (.mclk, .resetn, .regAddr, .regWdata, .regWr,
		.regRd, .regRdata, .motionStopped, .moveStart, .stopCmd, .fwResetReq, .linkActivity, .motionHalt,
		.alarm, .linkLost, .mon, .driverEnable, .windingCurrent);
	wpm_monitor_model model_i (.mclk, .faultSel, .mon);

	// Clock, random link traffic and the read-data watcher.
	always #10 mclk = ~mclk;
	always @(posedge mclk) linkActivity <= linkOn && ($urandom_range(3, 0) == 0);
	always @(posedge mclk) begin
		if (rdPend) begin
			chk("regRdata", notes[0].val & notes[0].msk, regRdata & notes[0].msk);
			void'(notes.pop_front());
		end
		rdPend <= regRd;
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic final_report();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask

	// The expected word is noted before the strobe; the watcher compares it one cycle later.
	task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
		@(posedge mclk);
		notes.push_back({e, m});
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
	endtask

	// A one-cycle movement start (mv set) or STOP command.
	task automatic kick(input logic mv);
		@(posedge mclk);
		if (mv) begin
			moveStart <= 1'b1;
			motionStopped <= 1'b0;
		end else stopCmd <= 1'b1;
		@(posedge mclk);
		moveStart <= 1'b0;
		stopCmd <= 1'b0;
	endtask

	function automatic logic [15:0] pick(input int s);
		case (s)
			0: return windingCurrent;
			1: return {15'h0, driverEnable};
			2: return {15'h0, alarm};
			default: return {15'h0, linkLost};
		endcase
	endfunction

	function automatic logic [15:0] win(input int lo, input int hi);
		return {15'h0, n >= lo && n <= hi};
	endfunction

	// Polls one result a cycle; running out of cycles ends the run as a failure.
	task automatic waitUntil(input int s, input logic [15:0] v, input int lim);
		n = 0;
		while (pick(s) !== v && n < lim) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n >= lim) begin
			num_errors++;
			$display("[ERR] wait %0d expected %h seen %h", s, v, pick(s));
			final_report();
		end
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		void'($urandom(38709));
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		for (int i = 0; i < 10; i++) rd(4'(i), rstv[i], 16'hffff);
		wr(4'hc, 16'hffff);
		for (int i = 12; i < 16; i++) rd(4'(i), 16'h0000, 16'hffff);
		waitUntil(0, 16'h03e8, 100);
		wr(REG_HOLDDLY, 16'h0005);
		@(posedge mclk) motionStopped <= 1'b1;
		waitUntil(0, 16'h01f4, 200);
		chk("holdDelay", 16'h1, win(35, 75));
		kick(1'b1);
		waitUntil(0, 16'h03e8, 20);
		wr(REG_OFFDLY, 16'h0001);
		@(posedge mclk) motionStopped <= 1'b1;
		waitUntil(1, 16'h0, 12000);
		chk("offDelay", 16'h1, win(9900, 10100));
		chk("windingCurrent", 16'h0, windingCurrent);
		wr(REG_OFFDLY, 16'h0002);
		waitUntil(1, 16'h1, 20);
		waitUntil(1, 16'h0, 12000);
		chk("newOffDelay", 16'h1, win(9800, 10100));
		@(posedge mclk) faultSel <= 3'h1;
		repeat (5) @(posedge mclk);
		#1 chk("alarm", 16'h0, {15'h0, alarm});
		faultSel <= 3'h0;
		wr(REG_CTRL, 16'h01ff);
		wr(REG_RAMP, 16'h0014);
		kick(1'b1);
		waitUntil(0, 16'h03e8, 400);
		chk("rampUp", 16'h1, win(170, 230));
		@(posedge mclk) motionStopped <= 1'b1;
		waitUntil(0, 16'h01f4, 300);
		chk("rampHold", 16'h1, win(130, 180));
		wr(REG_HOLD, 16'h0014);
		waitUntil(0, 16'h00c8, 300);
		chk("rampNewHold", 16'h1, win(100, 150));
		@(posedge mclk) fwResetReq <= 1'b1;
		@(posedge mclk) fwResetReq <= 1'b0;
		#1 chk("windingCurrent", 16'h0, windingCurrent);
		waitUntil(0, 16'h00c8, 400);
		for (int k = 1; k < 8; k++) begin
			@(posedge mclk) faultSel <= 3'(k);
			waitUntil(2, 16'h1, 5);
			chk("windingCurrent", 16'h0, windingCurrent);
			chk("motionHalt", 16'h1, {15'h0, motionHalt});
			rd(REG_STATUS, 16'h0400 | (16'h1 << (k - 1)), 16'h04ff);
			kick(1'b0);
			@(posedge mclk) faultSel <= 3'h0;
			repeat (3) @(posedge mclk);
			#1 chk("alarm", 16'h1, {15'h0, alarm});
			rd(REG_STATUS, 16'h0400 | (16'h1 << (k - 1)), 16'h04ff);
			kick(1'b0);
			waitUntil(2, 16'h0, 5);
			rd(REG_STATUS, 16'h0000, 16'h04ff);
		end
		@(posedge mclk) linkOn <= 1'b0;
		waitUntil(3, 16'h1, 100);
		chk("linkTimeout", 16'h1, win(30, 60));
		chk("alarm", 16'h0, {15'h0, alarm});
		linkOn <= 1'b1;
		waitUntil(3, 16'h0, 20);
		final_report();
	end
endmodule
`default_nettype wire

// ---- test/wpm_checker_assertions.sv ----
// Port-level assertions of the winding power manager.
`timescale 1ns/10ps
`default_nettype none
module wpm_checker (
	// Clock and reset.
	input wire logic        mclk,
	input wire logic        resetn,
	// Requests.
	input wire logic        regRd,
	input wire logic        stopCmd,
	input wire logic        fwResetReq,
	input wire logic        linkActivity,
	// Results.
	input wire logic [15:0] regRdata,
	input wire logic        motionHalt,
	input wire logic        alarm,
	input wire logic        linkLost,
	input wire logic        driverEnable,
	input wire logic [15:0] windingCurrent
);
	// One clock domain, so clock and reset are given once.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_alarm_zero_current: assert property (alarm |-> windingCurrent == 16'h0000)
		else $error("current not zero in alarm");
	a_fault_sets_alarm: assert property (motionHalt && !alarm |=> alarm)
		else $error("fault did not latch alarm");
	a_fwreset_zero: assert property (fwResetReq |=> windingCurrent == 16'h0000)
		else $error("firmware reset left current");
	a_driver_drop: assert property ($rose(alarm) |-> ##[0:2] !driverEnable)
		else $error("driver still enabled in alarm");
	a_enable_at_zero: assert property ($rose(driverEnable) |-> windingCurrent == 16'h0000)
		else $error("output enabled with current");
	a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 16'h0000)
		else $error("read data outside read slot");
	a_alarm_holds: assert property (alarm && !stopCmd |=> alarm)
		else $error("alarm left without stop");
	a_link_seen: assert property (linkActivity |=> !linkLost)
		else $error("link loss despite traffic");

	// Main scenarios are reached.
	c_alarm: cover property ($rose(alarm));
	c_power_off: cover property ($fell(driverEnable) && !alarm);
	c_link_lost: cover property ($rose(linkLost));
endmodule
bind winding_power_manager wpm_checker chk_i (.mclk, .resetn, .regRd, .stopCmd, .fwResetReq, .linkActivity,
	.regRdata, .motionHalt, .alarm, .linkLost, .driverEnable, .windingCurrent);
`default_nettype wire

// ---- test/wpm_monitor_model.sv ----
// Model of the supply, temperature and power-driver monitors beside the winding driver.
`timescale 1ns/10ps
`default_nettype none
module wpm_monitor_model
	import wpm_pkg::*;
(
	// Clock and fault selection.
	input  wire logic       mclk,
	input  wire logic [2:0] faultSel,
	// Monitor readings.
	output var  monitor_s   mon
);
	// Quiet readings at time zero; the design sits in reset until the first edges.
	initial mon = '0;

	// Code k puts cause k out of range, one cycle late like a real sampled monitor.
	always @(posedge mclk) begin
		mon.supplyMv10 <= (faultSel == 3'h1) ? 16'h0257 : (faultSel == 3'h2) ? 16'h1771 : 16'h0960;
		mon.supplyMa   <= (faultSel == 3'h3) ? 16'h0fa1 : 16'($urandom_range(3999, 0));
		mon.tempDc     <= (faultSel == 3'h4) ? 16'h02bd : 16'h00fa;
		mon.drvHot     <= (faultSel == 3'h5);
		mon.drvFault   <= (faultSel == 3'h6);
		mon.wrongLimit <= (faultSel == 3'h7);
	end
endmodule
`default_nettype wire
